// ===== hdl/sbm_branch_fsm.v
// Four-branch operating-mode state machine with AHB-Lite register slave
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "sbm_defs.vh"

module sbm_branch_fsm #(
  parameter LEGS = 4
) (
  // Clock and reset
  input  wire              clock,
  input  wire              nrst,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire              hready,
  input  wire [31:0]       hwdata,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  // Chip condition inputs, asynchronous
  input  wire              overheatFlag,
  input  wire              heatWarnFlag,
  input  wire [LEGS-1:0]   legStuckFlag,
  input  wire [LEGS-1:0]   legTxFault,
  input  wire [LEGS-1:0]   legIdle,
  input  wire [LEGS-1:0]   legTxDone,
  // Per-leg controls to transceiver and router
  output reg  [LEGS-1:0]   legTxEn,
  output reg  [LEGS-1:0]   legRxEn,
  output reg  [LEGS-1:0]   legWakeRxEn,
  output reg  [LEGS-1:0]   legErrDetEn,
  output reg  [LEGS-1:0]   legRouteEn,
  output reg  [LEGS-1:0]   legBiasGnd,
  output reg  [LEGS-1:0]   legBiasIdle
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam SW = 2 + 4 * LEGS;
  wire [SW-1:0] rawIn = {overheatFlag, heatWarnFlag, legStuckFlag, legTxFault,
                         legIdle, legTxDone};
  reg  [SW-1:0] sync1_reg;
  reg  [SW-1:0] sync2_reg;
  reg  [SW-1:0] sync3_reg;
  reg  [SW-1:0] clean_reg;
  reg  [SW-1:0] clean_next;
  integer k;

  // A change counts only once stages two and three agree
  always @* begin
    clean_next = clean_reg;
    for (k = 0; k < SW; k = k + 1) begin
      if (sync2_reg[k] == sync3_reg[k])
        clean_next[k] = sync3_reg[k];
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= {SW{1'b0}};
      sync2_reg <= {SW{1'b0}};
      sync3_reg <= {SW{1'b0}};
      clean_reg <= {SW{1'b0}};
    end else begin
      sync1_reg <= rawIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      clean_reg <= clean_next;
    end
  end

  wire            overheat = clean_reg[SW-1];
  wire            heatWarn = clean_reg[SW-2];
  wire [LEGS-1:0] stuck    = clean_reg[4*LEGS-1:3*LEGS];
  wire [LEGS-1:0] txFault  = clean_reg[3*LEGS-1:2*LEGS];
  wire [LEGS-1:0] idle     = clean_reg[2*LEGS-1:LEGS];
  wire [LEGS-1:0] txDone   = clean_reg[LEGS-1:0];
  wire            allIdle  = &idle;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  reg  [5:0]  ctrl_reg;
  reg  [7:0]  wAddr_reg;
  reg         wPend_reg;
  reg         cmdValid_reg;
  reg  [1:0]  cmdLeg_reg;
  reg  [1:0]  cmdCode_reg;
  reg  [LEGS*3-1:0] mode_reg;
  reg  [LEGS-1:0]   heatCause_reg;
  reg  [LEGS-1:0]   wasDis_reg;
  reg               overheatPrev_reg;
  reg  [2:0]        chipPrev_reg;

  wire [2:0] chipMode   = ctrl_reg[`SBM_CTRL_CHIP_LSB+2:`SBM_CTRL_CHIP_LSB];
  wire       hostCtl    = ctrl_reg[`SBM_CTRL_HOSTC_BIT];
  wire       autoIsoEn  = ctrl_reg[`SBM_CTRL_AFI_BIT];
  wire       stuckDetEn = ctrl_reg[`SBM_CTRL_STUCK_BIT];
  wire       addrPhase  = hsel & hready & htrans[1];

  // Zero wait states; unmapped reads give zero, unmapped writes are dropped
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata       <= 32'h00000000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      wAddr_reg    <= 8'h00;
      wPend_reg    <= 1'b0;
      ctrl_reg     <= `SBM_CTRL_RESET;
      cmdValid_reg <= 1'b0;
      cmdLeg_reg   <= 2'h0;
      cmdCode_reg  <= 2'h0;
    end else begin
      wPend_reg    <= addrPhase & hwrite;
      wAddr_reg    <= haddr;
      cmdValid_reg <= 1'b0;
      if (wPend_reg) begin
        case (wAddr_reg)
          `SBM_ADDR_CTRL: ctrl_reg <= hwdata[5:0];
          `SBM_ADDR_CMD: begin
            cmdValid_reg <= 1'b1;
            cmdLeg_reg   <= hwdata[`SBM_CMD_LEG_LSB+1:`SBM_CMD_LEG_LSB];
            cmdCode_reg  <= hwdata[`SBM_CMD_CODE_LSB+1:`SBM_CMD_CODE_LSB];
          end
          default: ;
        endcase
      end
      if (addrPhase && !hwrite) begin
        case (haddr)
          `SBM_ADDR_CTRL:   hrdata <= {26'h0000000, ctrl_reg};
          `SBM_ADDR_STATUS: hrdata <= {{(32-SW){1'b0}}, clean_reg};
          `SBM_ADDR_MODES:  hrdata <= {{(32-3*LEGS){1'b0}}, mode_reg};
          default:          hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Per-leg mode machines
  // ----------------------------------------
  wire chipOff  = (chipMode == `SBM_CHIP_UNPOWERED) || (chipMode == `SBM_CHIP_IN_RESET);
  wire chipLow  = (chipMode == `SBM_CHIP_IDLE_WAIT) || (chipMode == `SBM_CHIP_DORMANT);
  wire chipRun  = (chipMode == `SBM_CHIP_RUNNING);
  wire runEntry = chipRun && (chipPrev_reg != `SBM_CHIP_RUNNING);
  wire heatRise = overheat & ~overheatPrev_reg;
  wire cmdOk    = cmdValid_reg & chipRun;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overheatPrev_reg <= 1'b0;
      chipPrev_reg     <= `SBM_CHIP_UNPOWERED;
    end else begin
      overheatPrev_reg <= overheat;
      chipPrev_reg     <= chipMode;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LEGS; g = g + 1) begin : legGen
      reg  [2:0] mode_next;
      reg        cause_next;
      reg        wasDis_next;
      wire [2:0] mode   = mode_reg[3*g+2:3*g];
      wire       myCmd  = cmdOk && (cmdLeg_reg == g);

      always @* begin
        mode_next   = mode;
        cause_next  = heatCause_reg[g];
        wasDis_next = wasDis_reg[g];
        if (chipOff) begin
          mode_next   = `SBM_LEG_OFF;
          cause_next  = 1'b0;
          wasDis_next = 1'b0;
        end else if (chipLow) begin
          // Remember disabled legs across low power
          if (mode != `SBM_LEG_WAKE && mode != `SBM_LEG_OFF)
            wasDis_next = (mode == `SBM_LEG_DISABLED);
          mode_next = `SBM_LEG_WAKE;
        end else if (runEntry || mode == `SBM_LEG_WAKE || mode == `SBM_LEG_OFF) begin
          mode_next = wasDis_reg[g] ? `SBM_LEG_DISABLED : `SBM_LEG_NORMAL;
        end else begin
          case (mode)
            `SBM_LEG_NORMAL: begin
              if (heatRise) begin
                mode_next  = `SBM_LEG_DISABLED;
                cause_next = 1'b1;
              end else if (stuck[g] && stuckDetEn)
                mode_next = `SBM_LEG_MUTED;
              else if (txFault[g] && autoIsoEn)
                mode_next = `SBM_LEG_MUTED;
              else if (myCmd && cmdCode_reg == `SBM_CMD_SEND)
                mode_next = `SBM_LEG_SEND_HOST;
              else if (myCmd && cmdCode_reg == `SBM_CMD_DISABLE)
                mode_next = `SBM_LEG_DISABLED;
            end
            `SBM_LEG_DISABLED: begin
              if (myCmd && cmdCode_reg == `SBM_CMD_NORMAL) begin
                mode_next  = `SBM_LEG_NORMAL;
                cause_next = 1'b0;
              end else if (myCmd && cmdCode_reg == `SBM_CMD_SEND) begin
                mode_next  = `SBM_LEG_SEND_AUTO;
                cause_next = 1'b0;
              end else if (heatCause_reg[g] && !heatWarn) begin
                mode_next  = `SBM_LEG_NORMAL;
                cause_next = 1'b0;
              end
            end
            `SBM_LEG_SEND_AUTO: begin
              if (txFault[g])
                mode_next = `SBM_LEG_MUTED;
              else if (txDone[g])
                mode_next = `SBM_LEG_NORMAL;
            end
            `SBM_LEG_SEND_HOST: begin
              if (myCmd && cmdCode_reg == `SBM_CMD_NORMAL)
                mode_next = `SBM_LEG_NORMAL;
            end
            `SBM_LEG_MUTED: begin
              if (allIdle && (!hostCtl ||
                  (myCmd && cmdCode_reg == `SBM_CMD_SEND)))
                mode_next = `SBM_LEG_SEND_AUTO;
            end
            default: mode_next = `SBM_LEG_OFF;
          endcase
          // Anything else leaves the mode as it is; an unused mode code goes to OFF
        end
      end

      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          mode_reg[3*g+2:3*g] <= `SBM_LEG_OFF;
          heatCause_reg[g]    <= 1'b0;
          wasDis_reg[g]       <= 1'b0;
          legTxEn[g]          <= 1'b0;
          legRxEn[g]          <= 1'b0;
          legWakeRxEn[g]      <= 1'b0;
          legErrDetEn[g]      <= 1'b0;
          legRouteEn[g]       <= 1'b0;
          legBiasGnd[g]       <= 1'b0;
          legBiasIdle[g]      <= 1'b0;
        end else begin
          mode_reg[3*g+2:3*g] <= mode_next;
          heatCause_reg[g]    <= cause_next;
          wasDis_reg[g]       <= wasDis_next;
          // Outputs decoded from the next mode so they stay aligned with it
          legTxEn[g]     <= (mode_next == `SBM_LEG_NORMAL) || (mode_next == `SBM_LEG_SEND_AUTO)
                            || (mode_next == `SBM_LEG_SEND_HOST);
          legErrDetEn[g] <= (mode_next == `SBM_LEG_NORMAL) || (mode_next == `SBM_LEG_SEND_AUTO)
                            || (mode_next == `SBM_LEG_SEND_HOST);
          legRxEn[g]     <= (mode_next == `SBM_LEG_NORMAL) || (mode_next == `SBM_LEG_MUTED);
          legRouteEn[g]  <= (mode_next == `SBM_LEG_NORMAL);
          legWakeRxEn[g] <= (mode_next == `SBM_LEG_WAKE) || (mode_next == `SBM_LEG_DISABLED);
          legBiasGnd[g]  <= (mode_next == `SBM_LEG_WAKE);
          legBiasIdle[g] <= (mode_next != `SBM_LEG_OFF) && (mode_next != `SBM_LEG_WAKE);
        end
      end
    end
  endgenerate

endmodule

// ===== hdl/sbm_defs.vh
// Constants for the star branch mode state machine
`ifndef SBM_DEFS_VH
`define SBM_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SBM_ADDR_CTRL      8'h00
`define SBM_ADDR_CMD       8'h04
`define SBM_ADDR_STATUS    8'h08
`define SBM_ADDR_MODES     8'h0C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SBM_CTRL_CHIP_LSB  0
`define SBM_CTRL_HOSTC_BIT 3
`define SBM_CTRL_AFI_BIT   4
`define SBM_CTRL_STUCK_BIT 5
`define SBM_CTRL_RESET     6'h08

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define SBM_CMD_LEG_LSB    0
`define SBM_CMD_CODE_LSB   2

// ----------------------------------------
// Chip operating modes
// ----------------------------------------
`define SBM_CHIP_UNPOWERED 3'h0
`define SBM_CHIP_IN_RESET  3'h1
`define SBM_CHIP_IDLE_WAIT 3'h2
`define SBM_CHIP_DORMANT   3'h3
`define SBM_CHIP_RUNNING   3'h4

// ----------------------------------------
// Host branch commands
// ----------------------------------------
`define SBM_CMD_NONE       2'h0
`define SBM_CMD_NORMAL     2'h1
`define SBM_CMD_SEND       2'h2
`define SBM_CMD_DISABLE    2'h3

// ----------------------------------------
// Branch modes
// ----------------------------------------
`define SBM_LEG_OFF        3'h0
`define SBM_LEG_WAKE       3'h1
`define SBM_LEG_DISABLED   3'h2
`define SBM_LEG_NORMAL     3'h3
`define SBM_LEG_SEND_AUTO  3'h4
`define SBM_LEG_SEND_HOST  3'h5
`define SBM_LEG_MUTED      3'h6

`endif

// ===== testbench/sbm_props.sv
// Port-level properties of the star branch mode machine
`timescale 1ns/10ps
module sbm_props #(
  parameter LEGS = 4
) (
  // Clock and reset
  input wire logic            clock,
  input wire logic            nrst,
  // Bus answer
  input wire logic            hreadyout,
  input wire logic            hresp,
  // Leg controls
  input wire logic [LEGS-1:0] legTxEn,
  input wire logic [LEGS-1:0] legRxEn,
  input wire logic [LEGS-1:0] legWakeRxEn,
  input wire logic [LEGS-1:0] legErrDetEn,
  input wire logic [LEGS-1:0] legRouteEn,
  input wire logic [LEGS-1:0] legBiasGnd,
  input wire logic [LEGS-1:0] legBiasIdle
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_ROUTE: assert property ((legRouteEn & ~(legTxEn & legRxEn & legErrDetEn)) == '0)
    else $error("route without full leg");
  AST_TXERR: assert property (legTxEn == legErrDetEn)
    else $error("tx and error detect differ");
  AST_WAKE: assert property ((legWakeRxEn & (legTxEn | legRxEn | legErrDetEn)) == '0)
    else $error("wake rx beside active path");
  AST_GND: assert property ((legBiasGnd & ~legWakeRxEn) == '0)
    else $error("ground bias without wake rx");
  AST_BIAS: assert property ((legBiasGnd & legBiasIdle) == '0)
    else $error("two biases at once");
  AST_FLOAT: assert property
    ((~(legWakeRxEn | legTxEn | legRxEn) & (legBiasGnd | legBiasIdle)) == '0)
    else $error("off leg not floating");
  AST_IDLE: assert property (((legTxEn | legRxEn) & ~legBiasIdle) == '0)
    else $error("active leg not idle biased");
  AST_READY: assert property (hreadyout && !hresp ##1 hreadyout && !hresp)
    else $error("bus not ready or not okay");
  // Main scenarios reached
  cover property ((legRouteEn) != '0);
  cover property ((legTxEn & ~legRouteEn) != '0);
  cover property ((legRxEn & ~legTxEn) != '0);
endmodule

bind sbm_branch_fsm sbm_props #(.LEGS(LEGS)) sbm_props_inst (.clock(clock), .nrst(nrst),
  .hreadyout(hreadyout), .hresp(hresp), .legTxEn(legTxEn), .legRxEn(legRxEn),
  .legWakeRxEn(legWakeRxEn), .legErrDetEn(legErrDetEn), .legRouteEn(legRouteEn),
  .legBiasGnd(legBiasGnd), .legBiasIdle(legBiasIdle));

// ===== testbench/sbm_leg_model.sv
// Behavioural model of the four leg transceivers
`timescale 1ns/10ps
module sbm_leg_model (
  // Clock
  input wire logic        clock,
  // From block and bench
  input wire logic [3:0]  legTxEn,
  input wire logic [3:0]  frameReq,
  input wire logic [3:0]  faultReq,
  input wire logic [3:0]  busy,
  // To block
  output logic     [3:0]  legIdle,
  output logic     [3:0]  legTxDone,
  output logic     [3:0]  legTxFault
);
  always @(posedge clock) begin
    legIdle <= ~busy & ~frameReq;
    // Faults only show on legs that drive the bus
    legTxFault <= faultReq & legTxEn;
    legTxDone <= frameReq & legTxEn & ~faultReq;
  end
endmodule

// ===== testbench/tb.sv
// Self-checking testbench for the star branch mode machine
`timescale 1ns/10ps
module tb;
  logic        clock = 0;
  logic        nrst = 0;
  logic        hsel = 0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 32'h0;
  logic        overheatFlag = 0;
  logic        heatWarnFlag = 0;
  logic [3:0]  legStuckFlag = 4'h0;
  logic [3:0]  busy = 4'h0;
  logic [3:0]  frameReq = 4'h0;
  logic [3:0]  faultReq = 4'h0;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [3:0]  legTxEn, legIdle, legTxDone, legTxFault;
  int          n_errors = 0;
  int          compares = 0;
  always #12.5 clock = ~clock;
  sbm_branch_fsm sbm_branch_fsm_inst (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .overheatFlag(overheatFlag),
    .heatWarnFlag(heatWarnFlag), .legStuckFlag(legStuckFlag), .legTxFault(legTxFault),
    .legIdle(legIdle), .legTxDone(legTxDone), .legTxEn(legTxEn), .legRxEn(),
    .legWakeRxEn(), .legErrDetEn(), .legRouteEn(), .legBiasGnd(), .legBiasIdle());
  sbm_leg_model sbm_leg_model_inst (.clock(clock), .legTxEn(legTxEn), .frameReq(frameReq),
    .faultReq(faultReq), .busy(busy), .legIdle(legIdle), .legTxDone(legTxDone),
    .legTxFault(legTxFault));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(posedge clock);
      t++;
    end while (hreadyout !== 1'h1 && t < 50);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do begin
      @(posedge clock);
      t++;
    end while (hreadyout !== 1'h1 && t < 100);
    rd = hrdata;
    if (t >= 100) n_errors++;
  endtask
  task automatic settle;
    repeat (12) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
    settle;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    compares++;
    if (rd !== e) begin
      n_errors++;
      $display("mismatch at %0t: reg %h got %h want %h", $time, a, rd, e);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog and tests
  // ----------------------------------------
  initial begin
    #125000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    chk(8'h00, 32'h08);
    chk(8'h0C, 32'h0);
    chk(8'h10, 32'h0);
    chk(8'h08, 32'hF0);
    wr(8'h04, 32'hC);
    wr(8'h00, 32'h0A);
    chk(8'h0C, 32'h249);
    wr(8'h04, 32'hC);
    wr(8'h00, 32'h0C);
    chk(8'h0C, 32'h6DB);
    wr(8'h04, 32'hD);
    chk(8'h0C, 32'h6D3);
    wr(8'h00, 32'h0B);
    chk(8'h0C, 32'h249);
    wr(8'h00, 32'h0C);
    chk(8'h0C, 32'h6D3);
    wr(8'h04, 32'h9);
    chk(8'h0C, 32'h6E3);
    frameReq <= 4'h2;
    settle;
    frameReq <= 4'h0;
    settle;
    chk(8'h0C, 32'h6DB);
    wr(8'h04, 32'hA);
    chk(8'h0C, 32'h75B);
    wr(8'h04, 32'h6);
    chk(8'h0C, 32'h6DB);
    wr(8'h00, 32'h2C);
    busy <= 4'h8;
    legStuckFlag <= 4'h1;
    settle;
    legStuckFlag <= 4'h0;
    settle;
    chk(8'h0C, 32'h6DE);
    wr(8'h04, 32'h8);
    chk(8'h0C, 32'h6DE);
    busy <= 4'h0;
    settle;
    chk(8'h0C, 32'h6DE);
    wr(8'h04, 32'h8);
    chk(8'h0C, 32'h6DC);
    faultReq <= 4'h1;
    settle;
    faultReq <= 4'h0;
    settle;
    chk(8'h0C, 32'h6DE);
    wr(8'h00, 32'h04);
    chk(8'h0C, 32'h6DC);
    heatWarnFlag <= 1'h1;
    overheatFlag <= 1'h1;
    settle;
    chk(8'h0C, 32'h494);
    overheatFlag <= 1'h0;
    heatWarnFlag <= 1'h0;
    settle;
    chk(8'h0C, 32'h6DC);
    wr(8'h00, 32'h14);
    busy <= 4'h8;
    faultReq <= 4'h2;
    settle;
    faultReq <= 4'h0;
    settle;
    chk(8'h0C, 32'h6F4);
    busy <= 4'h0;
    settle;
    chk(8'h0C, 32'h6E4);
    report_and_stop;
  end
endmodule
